// ---- inc/rate_pkg.sv ----
// Package for the automatic RS-485 direction controller of the second
// serial port: mode codes, frame-format values and character timing.
// Assumes a 25 MHz board logic clock.
package rate_pkg;

  // Clock rate in hertz.
  localparam int unsigned CLK_HZ = 25000000;

  // Port mode codes.
  localparam logic [2:0] MODE_RS232   = 3'h0;
  localparam logic [2:0] MODE_FD485   = 3'h1;
  localparam logic [2:0] MODE_RESET   = 3'h0;
  localparam int unsigned MODE_HD_BIT = 2;

  // Frame-format register.
  localparam logic FMT_SHORT = 1'h0;
  localparam logic FMT_LONG  = 1'h1;
  localparam logic FMT_RESET = 1'h0;

  // Half-duplex baud rates, indexed by the two low mode bits.
  localparam int unsigned BAUD_0 = 9600;
  localparam int unsigned BAUD_1 = 19200;
  localparam int unsigned BAUD_2 = 57600;
  localparam int unsigned BAUD_3 = 115200;

  // Character lengths in bit times, start and stop bits included.
  localparam int unsigned BITS_SHORT = 10;
  localparam int unsigned BITS_LONG  = 11;

  // Cycles per character, rounded up so the driver never drops early.
  localparam int unsigned CW = 16;
  function automatic logic [CW-1:0] char_cycles(input int unsigned baud,
                                                input int unsigned bits);
    char_cycles = CW'((CLK_HZ * bits + baud - 1) / baud);
  endfunction : char_cycles

  // Mode and format as one carrier.
  typedef struct packed {
    logic [2:0] mode;
    logic       fmt;
  } rate_cfg_t;

  // Transceiver controls as one carrier.
  typedef struct packed {
    logic drv_en;
    logic rcv_en_n;
    logic rs485_sel;
  } rate_xcvr_t;

endpackage : rate_pkg

// ---- src/rate_char_timer.sv ----
// Character timer: reloads on each start bit and counts one character.
// Assumes load values come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module rate_char_timer
  import rate_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // Control
  input  wire logic          load_i,
  input  wire logic [CW-1:0] len_i,
  input  wire logic          abort_i,
  // Status
  output logic               busy_o
);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } rate_tmr_t;

  rate_tmr_t st;
  rate_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (abort_i) begin
      next_st.cnt = '0;
    end else if (load_i) begin
      next_st.cnt = len_i;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - CW'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign busy_o = (st.cnt != '0);

endmodule : rate_char_timer
`default_nettype wire

// ---- src/rate_ctrl.sv ----
// Automatic RS-485 transmit-enable controller for the second serial port.
// Assumes the UART transmit line arrives asynchronously and idles high,
// and that mode and format inputs are set once by software.
// Summary of operation
// - Reset selects RS-232, driver never enabled.
// - Mode one: full duplex, driver always on.
// - Top bit half duplex; codes pick baud.
// - Format flag lengthens character by one bit.
// - Half duplex switches driver and receiver itself.
// - Only four baud rates timed correctly.
`timescale 1ns/100ps
`default_nettype none
module rate_ctrl
  import rate_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // Configuration written by software
  input  wire logic       cfg_we_i,
  input  wire rate_cfg_t  cfg_i,
  output var  rate_cfg_t  cfg_o,
  // UART transmit line
  input  wire logic       uart_txd_i,
  // Transceiver controls
  output var  rate_xcvr_t xcvr_o
);

  // Half duplex is split into a receive and a send state so that the
  // line turnaround can be read straight from the state register.
  typedef enum logic [3:0] {
    S_RS232   = 4'h1,
    S_FULL    = 4'h2,
    S_HD_RECV = 4'h4,
    S_HD_SEND = 4'h8
  } rate_state_t;

  typedef struct packed {
    rate_cfg_t     cfg;
    rate_state_t   fsm;
    logic [1:0]    sync;
    logic          txd_q;
    logic [CW-1:0] len;
    rate_xcvr_t    xcvr;
  } rate_reg_t;

  rate_reg_t st;
  rate_reg_t next_st;
  logic      busy;
  logic      start;

  // Half-duplex operation is chosen by the top mode bit alone.
  function automatic logic is_hd_mode(input logic [2:0] mode);
    is_hd_mode = mode[MODE_HD_BIT];
  endfunction : is_hd_mode

  // Entry state for a stored mode code.
  function automatic rate_state_t mode_state(input logic [2:0] mode);
    rate_state_t s;
    s = S_RS232;
    if (is_hd_mode(mode)) begin
      s = S_HD_RECV;
    end else if (mode == MODE_FD485) begin
      s = S_FULL;
    end else begin
      // Reserved codes fall back to RS-232 so the line is never driven.
      s = S_RS232;
    end
    mode_state = s;
  endfunction : mode_state

  // True in either half-duplex state.
  function automatic logic is_half(input rate_state_t s);
    is_half = (s == S_HD_RECV) || (s == S_HD_SEND);
  endfunction : is_half

  // Falling edge between two successive samples of the line.
  function automatic logic fell_edge(input logic prev, input logic now);
    fell_edge = prev && !now;
  endfunction : fell_edge

  // Transceiver controls for a state; act is set while a character is
  // on the line.
  function automatic rate_xcvr_t drive_for(input rate_state_t s,
                                           input logic        act);
    rate_xcvr_t x;
    x = '0;
    case (s)
      S_RS232: begin
        x.drv_en    = 1'b0;
        x.rcv_en_n  = 1'b0;
        x.rs485_sel = 1'b0;
      end
      S_FULL: begin
        x.drv_en    = 1'b1;
        x.rcv_en_n  = 1'b0;
        x.rs485_sel = 1'b1;
      end
      S_HD_RECV, S_HD_SEND: begin
        // Driver and receiver always swap together, so the node neither
        // hears its own echo nor talks over the line while idle.
        x.drv_en    = act;
        x.rcv_en_n  = act;
        x.rs485_sel = 1'b1;
      end
      default: begin
        x = '0;
      end
    endcase
    drive_for = x;
  endfunction : drive_for

  // Bit times in one character: start, eight data and stop bits, plus
  // one more for parity or a second stop bit.
  function automatic int unsigned char_bits(input logic fmt);
    int unsigned n;
    n = BITS_SHORT;
    if (fmt == FMT_LONG) begin
      n = BITS_LONG;
    end
    char_bits = n;
  endfunction : char_bits

  // Baud rate picked by the two low mode bits in half-duplex operation.
  function automatic int unsigned baud_of(input logic [1:0] sel);
    int unsigned b;
    b = BAUD_0;
    case (sel)
      2'h0: b = BAUD_0;
      2'h1: b = BAUD_1;
      2'h2: b = BAUD_2;
      2'h3: b = BAUD_3;
      default: b = BAUD_0;
    endcase
    baud_of = b;
  endfunction : baud_of

  // Character length in clock cycles for a stored configuration.
  function automatic logic [CW-1:0] pick_len(input rate_cfg_t c);
    pick_len = char_cycles(baud_of(c.mode[1:0]), char_bits(c.fmt));
  endfunction : pick_len

  // Falling edge on the synchronised line marks a start bit.
  assign start = is_half(st.fsm) && fell_edge(st.txd_q, st.sync[1]);

  // The timer is cleared whenever the port leaves half duplex, so a
  // stale count can never hold the driver on in another mode.
  rate_char_timer u_tmr (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (start),
    .len_i   (st.len),
    .abort_i (!is_half(st.fsm)),
    .busy_o  (busy)
  );

  always_comb begin
    next_st = st;
    // Two-flop synchroniser; only the second stage feeds the edge logic.
    next_st.sync  = {st.sync[0], uart_txd_i};
    next_st.txd_q = st.sync[1];
    if (cfg_we_i) begin
      next_st.cfg = cfg_i;
    end
    // The length is registered from the stored configuration so the
    // timer load never waits on the rate decode; the one cycle of lag
    // is hidden behind the synchroniser.
    next_st.len = pick_len(st.cfg);

    case (st.fsm)
      S_RS232, S_FULL: begin
        next_st.fsm = mode_state(st.cfg.mode);
      end
      S_HD_RECV: begin
        if (!is_hd_mode(st.cfg.mode)) begin
          next_st.fsm = mode_state(st.cfg.mode);
        end else if (start) begin
          next_st.fsm = S_HD_SEND;
        end
      end
      S_HD_SEND: begin
        // The timer spans the whole character, so the driver stays on
        // while the holding and shift stages drain back to back.
        if (!is_hd_mode(st.cfg.mode)) begin
          next_st.fsm = mode_state(st.cfg.mode);
        end else if (!start && !busy) begin
          next_st.fsm = S_HD_RECV;
        end
      end
      default: begin
        next_st.fsm = S_RS232;
      end
    endcase

    // Controls follow the registered state, so a mode change reaches the
    // pins one cycle after the state register.
    next_st.xcvr = drive_for(st.fsm, next_st.fsm == S_HD_SEND);
  end

  // The synchroniser resets to the idle mark level, so no false start
  // bit is seen as reset is released.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.cfg   <= '{mode: MODE_RESET, fmt: FMT_RESET};
      st.fsm   <= S_RS232;
      st.sync  <= 2'h3;
      st.txd_q <= 1'b1;
      st.len   <= '0;
      st.xcvr  <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign cfg_o  = st.cfg;
  assign xcvr_o = st.xcvr;

endmodule : rate_ctrl
`default_nettype wire

// ---- test/rate_monitor.sv ----
// Port checker for rate_ctrl, bound from the bench.
`timescale 1ns/100ps
`default_nettype none
module rate_monitor
  import rate_pkg::*;
(
  // Watched ports
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire rate_cfg_t  cfg_o,
  input wire logic       uart_txd_i,
  input wire rate_xcvr_t xcvr_o
);
  logic [15:0] gap;
  logic [15:0] lim;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since the last start edge; hold limits are judged from it.
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i) gap <= 16'h0;
    else gap <= $fell(uart_txd_i) ? 16'h0 : gap + 16'h1;
  always_comb
    case (cfg_o.mode[1:0])
      2'h0: lim = cfg_o.fmt ? 16'h6fe6 : 16'h65ba;
      2'h1: lim = cfg_o.fmt ? 16'h37f3 : 16'h32dd;
      2'h2: lim = cfg_o.fmt ? 16'h12a7 : 16'h10f5;
      default: lim = cfg_o.fmt ? 16'h0954 : 16'h087b;
    endcase
  a_reset_idle: assert property (!$past(rst_n_i) |->
    cfg_o == 4'h0 && xcvr_o == 3'h0) else $error("not idle at reset");
  a_rs232_off: assert property (cfg_o.mode == 3'h0 [*3] |->
    xcvr_o == 3'h0) else $error("driver on in rs232");
  a_resv_off: assert property (cfg_o.mode[2:1] == 2'h1 [*3] |->
    xcvr_o == 3'h0) else $error("reserved code active");
  a_fd_on: assert property (cfg_o.mode == 3'h1 [*3] |->
    xcvr_o == 3'h5) else $error("full duplex driver off");
  a_hd_start: assert property (cfg_o.mode[2] && $fell(uart_txd_i)
    |-> ##[1:6] xcvr_o == 3'h7) else $error("no turn on");
  a_hd_pair: assert property (cfg_o.mode[2] [*3] |->
    xcvr_o.rcv_en_n == xcvr_o.drv_en && xcvr_o.rs485_sel)
    else $error("bad direction pair");
  a_hold_min: assert property (cfg_o.mode[2]
    && $fell(xcvr_o.drv_en) |-> gap >= lim + 16'h1) else $error("early off");
  a_hold_max: assert property (cfg_o.mode[2]
    && xcvr_o.drv_en |-> gap <= lim + 16'h8) else $error("late off");
  c_fd: cover property (xcvr_o == 3'h5);
  c_hd: cover property (cfg_o.mode[2] && $fell(xcvr_o.drv_en));
  c_b2b: cover property (xcvr_o.drv_en && $fell(uart_txd_i));
endmodule : rate_monitor
`default_nettype wire

// ---- test/rate_xcvr_model.sv ----
// Half-duplex transceiver; the pair idles at mark by fail-safe bias.
`timescale 1ns/100ps
`default_nettype none
module rate_xcvr_model (
  input  wire logic drv_en_i,
  input  wire logic rcv_en_n_i,
  input  wire logic txd_i,
  output logic      line_o,
  output logic      rxd_o
);
  assign line_o = drv_en_i ? txd_i : 1'b1;
  // A disabled receiver output is pulled up.
  assign rxd_o = rcv_en_n_i ? 1'b1 : line_o;
endmodule : rate_xcvr_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Bench for rate_ctrl; the bench plays the UART, a model the transceiver.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rate_pkg::*;
;
  logic       mclk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic       cfg_we_i = 1'b0, uart_txd_i = 1'b1, line, rxd, f;
  rate_cfg_t  cfg_i = 4'h0, cfg_o;
  rate_xcvr_t xcvr_o;
  int         failures, tests_run, lim, bd[4];
  longint     t0, d, exq[$];
  initial forever #20 mclk_i = ~mclk_i;
  rate_ctrl u_dut (.mclk_i, .rst_n_i, .ce_i, .cfg_we_i, .cfg_i, .cfg_o,
    .uart_txd_i, .xcvr_o);
  rate_xcvr_model u_xcvr (.drv_en_i(xcvr_o.drv_en), .txd_i(uart_txd_i),
    .rcv_en_n_i(xcvr_o.rcv_en_n), .line_o(line), .rxd_o(rxd));
  task automatic cmp(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic cfg(input logic [3:0] v);
    cfg_i = v;
    cfg_we_i = 1'b1;
    @(negedge mclk_i) cfg_we_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    cmp(cfg_o, v);
  endtask : cfg
  // Start bit only; the rest of the frame stays at mark.
  task automatic send(input int bt, input logic en, hd);
    uart_txd_i = 1'b0;
    t0 = $time;
    repeat (bt / 2) @(negedge mclk_i);
    cmp({line, rxd}, {~en, hd | ~en});
    repeat (bt - bt / 2) @(negedge mclk_i);
    uart_txd_i = 1'b1;
  endtask : send
  always @(negedge xcvr_o.drv_en)
    if (exq.size() > 0) begin
      d = ($time - t0) / 40 - exq.pop_front();
      cmp(d inside {[1:8]} ? 16'h1 : 16'(d), 16'h1);
    end
  initial begin
    bd = '{BAUD_0, BAUD_1, BAUD_2, BAUD_3};
    void'($urandom(24));
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i) rst_n_i = 1'b1;
    cmp({cfg_o, xcvr_o}, 7'h0);
    for (int m = 0; m < 8; m++) begin
      f = 1'($urandom);
      cfg({m[2:0], f});
      lim = (CLK_HZ * (10 + f) + bd[m % 4] - 1) / bd[m % 4];
      if (m[2]) exq.push_back(lim);
      send(lim / (10 + f), m == 1 || m[2], m[2]);
      if (!m[2]) cmp(xcvr_o, m == 1 ? 3'h5 : 3'h0);
      if (m[2]) repeat (lim + 20) @(negedge mclk_i);
      if (m[2]) cmp(xcvr_o, 3'h1);
      $display("mode %0d done", m);
    end
    exq.push_back(lim);
    send(lim / (10 + f), 1'b1, 1'b1);
    repeat (lim / 2 + $urandom % 64) @(negedge mclk_i);
    send(lim / (10 + f), 1'b1, 1'b1);
    repeat (lim + 20) @(negedge mclk_i);
    cmp(xcvr_o, 3'h1);
    cmp(16'(exq.size()), 16'h0);
    $display("back to back done");
    ce_i = 1'b0;
    cfg_i = 4'h0;
    cfg_we_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    cmp(cfg_o, {3'h7, f});
    cfg_we_i = 1'b0;
    ce_i = 1'b1;
    $display("freeze done");
    end_sim();
  end
  initial begin
    #3200000;
    failures++;
    end_sim();
  end
endmodule : tb_top
bind rate_ctrl rate_monitor u_mon (.mclk_i, .rst_n_i, .cfg_o, .uart_txd_i,
  .xcvr_o);
`default_nettype wire
